// File: rtl/sfbc_pkg.sv
// Shared constants for the synthesizer and bit rate control block.
package sfbc_pkg;
   // Register addresses on the serial register port.
   localparam logic [6:0] ADDR_OPMODE = 7'h01;
   localparam logic [6:0] ADDR_BR_HI  = 7'h02;
   localparam logic [6:0] ADDR_BR_LO  = 7'h03;
   localparam logic [6:0] ADDR_FRF_HI = 7'h06;
   localparam logic [6:0] ADDR_FRF_MD = 7'h07;
   localparam logic [6:0] ADDR_FRF_LO = 7'h08;
   localparam logic [6:0] ADDR_PLL    = 7'h0A;
   localparam logic [6:0] ADDR_OSC    = 7'h0B;
   localparam logic [6:0] ADDR_MAP2   = 7'h0C;
   localparam logic [6:0] ADDR_FRAC   = 7'h0D;
   localparam logic [6:0] ADDR_REFSRC = 7'h0E;
   localparam logic [6:0] ADDR_STATUS = 7'h10;
   // Field positions.
   localparam int OPM_OOK_BIT   = 3;
   localparam int OPM_GAUSS_BIT = 4;
   localparam int OPM_CONT_BIT  = 5;
   localparam int PLL_LN_BIT    = 2;
   localparam int OSC_TRIG_BIT  = 0;
   localparam int OSC_DONE_BIT  = 1;
   localparam int SPI_WR_BIT    = 7;
   // Operating modes, and the clock select code that turns the clock output off.
   localparam logic [2:0] MODE_SLEEP = 3'h0;
   localparam logic [2:0] MODE_TX    = 3'h3;
   localparam logic [2:0] REFERENCE_CLOCK_OUTPUT_OFF = 3'h7;
   // Values after reset.
   localparam logic [7:0] RST_OPMODE = 8'h01;
   localparam logic [7:0] RST_BR_HI  = 8'h1A;
   localparam logic [7:0] RST_BR_LO  = 8'h0B;
   localparam logic [7:0] RST_FRF    = 8'h00;
   localparam logic [2:0] RST_PLL    = 3'h0;
   localparam logic [2:0] RST_CLKSEL = 3'h0;
   localparam logic [3:0] RST_FRAC   = 4'h0;
   // Timing.
   localparam int CLK_FREQ_MHZ   = 100;
   localparam int RC_CAL_TIME_NS = 1000;
   localparam int RC_CAL_CYCLES  =
      (RC_CAL_TIME_NS * CLK_FREQ_MHZ + 999) / 1000;
   localparam logic [15:0] BR_MIN_DIV = 16'h0002;
endpackage

// File: rtl/sfbc_bit_if.sv
// Link between the control logic and the bit clock generator.
`timescale 1ns/1ns
interface sfbc_bit_if;
   logic [15:0] div_int;
   logic [3:0]  div_frac;
   logic        run;
   logic        tick;
   logic        half;
   modport ctl (output div_int, output div_frac, output run,
                input tick, input half);
   modport gen (input div_int, input div_frac, input run,
                output tick, output half);
endinterface

// File: rtl/sfbc_bit_gen.sv
// Fractional bit period generator.
`timescale 1ns/1ns
module sfbc_bit_gen
   import sfbc_pkg::*;
(
   input  wire logic core_clk,
   input  wire logic reset_n,
   sfbc_bit_if.gen   b
);
   logic [16:0] cnt_ff;
   logic [16:0] nxt_cnt_ff;
   logic [3:0]  acc_ff;
   logic [3:0]  nxt_acc_ff;
   logic        ext_ff;
   logic        nxt_ext_ff;
   logic [15:0] div_c;
   logic [16:0] period;
   logic        tick;

   // Periods below two cycles cannot show a high and a low half.
   assign div_c  = (b.div_int < BR_MIN_DIV) ? BR_MIN_DIV : b.div_int;
   assign period = {1'b0, div_c} + {16'h0000, ext_ff};
   assign b.tick = tick;
   // Mid bit falls one cycle early so a two-cycle bit still shows a low.
   assign b.half = b.run &&
                   (cnt_ff == {1'b0, period[16:1]} - 17'h00001);

   always_comb begin
      nxt_cnt_ff = cnt_ff + 17'h00001;
      nxt_acc_ff = acc_ff;
      nxt_ext_ff = ext_ff;
      tick       = 1'b0;
      if (!b.run) begin
         nxt_cnt_ff = 17'h00000;
         nxt_acc_ff = 4'h0;
         nxt_ext_ff = 1'b0;
      end else if (cnt_ff >= period - 17'h00001) begin
         tick       = 1'b1;
         nxt_cnt_ff = 17'h00000;
         // The fraction piles up in sixteenths and a carry stretches
         // the next bit by one cycle, so the mean period is exact.
         {nxt_ext_ff, nxt_acc_ff} =
            {1'b0, acc_ff} + {1'b0, b.div_frac};
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= 17'h00000;
         acc_ff <= 4'h0;
         ext_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt_ff;
         acc_ff <= nxt_acc_ff;
         ext_ff <= nxt_ext_ff;
      end
   end
endmodule

// File: rtl/sfbc_top.sv
// Synthesizer, reference clock and bit rate control with register port.
// Function
// - Crystal clock drives synthesizer and all logic.
// - PLL starts by itself once crystal stable.
// - Clock pin carries reference divided by two up to 128, never the undivided reference.
// - Clock output on at reset, off in sleep.
// - Low noise PLL only in transmit.
// - Two bit bandwidth picks one of four.
// - Frequency step is crystal over two^19.
// - Carrier is step times 24-bit word.
// - Upper bytes wait until low byte written.
// - RC oscillator calibrates itself at power-up.
// - Trigger runs calibration, then sets done flag.
// - Plain continuous data asynchronous, Gaussian uses clock.
// - Bit rate is crystal over divider plus fraction.
// - On-off keying forces the fraction to zero.
// - Fractional divider keeps rate error within 250ppm.
// - Bit clock pulses for every new transmit bit in continuous Gaussian mode only.
`timescale 1ns/1ns
module sfbc_top
   import sfbc_pkg::*;
(
   input  wire logic        core_clk,
   input  wire logic        reset_n,
   input  wire logic        spi_sck,
   input  wire logic        spi_nss_n,
   input  wire logic        spi_mosi,
   output logic             spi_miso_ff,
   output logic             spi_miso_oe_ff,
   input  wire logic        serial_tx_data_pin,
   input  wire logic        xo_stable,
   output logic             clock_output_pin_ff,
   output logic             serial_bit_clock_pin_ff,
   output logic             tx_mod_data_ff,
   output logic [23:0]      carrier_frequency_word_ff,
   output logic [1:0]       pll_bandwidth_ff,
   output logic             pll_low_noise_ff,
   output logic             pll_start_ff,
   output logic             external_reference_select_ff,
   output logic             rc_cal_active_ff
);
   typedef enum logic [0:0] {RC_IDLE = 1'b0, RC_RUN = 1'b1} sfbc_rc_e;

   localparam int RC_BOUND = RC_CAL_CYCLES + 10;

   // Pin synchronisers: sck, nss, mosi, data, crystal ready.
   logic [4:0]  s1_ff;
   logic [4:0]  s2_ff;
   logic        sck_d_ff;
   logic        sck_s;
   logic        nss_s;
   logic        mosi_s;
   logic        data_s;
   logic        xo_s;
   logic        sck_rise;
   logic        sck_fall;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         s1_ff    <= 5'h02;
         s2_ff    <= 5'h02;
         sck_d_ff <= 1'b0;
      end else begin
         s1_ff    <= {xo_stable, serial_tx_data_pin, spi_mosi,
                      spi_nss_n, spi_sck};
         s2_ff    <= s1_ff;
         sck_d_ff <= s2_ff[0];
      end
   end

   assign sck_s    = s2_ff[0];
   assign nss_s    = s2_ff[1];
   assign mosi_s   = s2_ff[2];
   assign data_s   = s2_ff[3];
   assign xo_s     = s2_ff[4];
   assign sck_rise = sck_s && !sck_d_ff;
   assign sck_fall = !sck_s && sck_d_ff;

   // Register state.
   logic [2:0]  mode_ff, nxt_mode_ff;
   logic        ook_ff, nxt_ook_ff;
   logic        gauss_ff, nxt_gauss_ff;
   logic        cont_ff, nxt_cont_ff;
   logic [7:0]  br_hi_ff, nxt_br_hi_ff;
   logic [7:0]  br_lo_ff, nxt_br_lo_ff;
   logic [3:0]  frac_ff, nxt_frac_ff;
   logic [7:0]  frf_hi_ff, nxt_frf_hi_ff;
   logic [7:0]  frf_md_ff, nxt_frf_md_ff;
   logic [23:0] nxt_frf_ff;
   logic [1:0]  bw_ff, nxt_bw_ff;
   logic        ln_req_ff, nxt_ln_req_ff;
   logic [2:0]  clksel_ff, nxt_clksel_ff;
   logic        nxt_ext_ref_ff;
   logic        rc_done_ff;

   // Serial port state.
   logic [3:0]  bcnt_ff, nxt_bcnt_ff;
   logic [7:0]  sh_ff, nxt_sh_ff;
   logic [7:0]  osh_ff, nxt_osh_ff;
   logic [6:0]  addr_ff, nxt_addr_ff;
   logic        wr_ff, nxt_wr_ff;
   logic        ph_ff, nxt_ph_ff;
   logic        nxt_miso_ff;
   logic        wr_stb;
   logic [7:0]  wdata;

   function automatic logic [7:0] rd_mux(input logic [6:0] a);
      unique case (a)
         ADDR_OPMODE: rd_mux = {2'b00, cont_ff, gauss_ff, ook_ff,
                                mode_ff};
         ADDR_BR_HI:  rd_mux = br_hi_ff;
         ADDR_BR_LO:  rd_mux = br_lo_ff;
         ADDR_FRF_HI: rd_mux = carrier_frequency_word_ff[23:16];
         ADDR_FRF_MD: rd_mux = carrier_frequency_word_ff[15:8];
         ADDR_FRF_LO: rd_mux = carrier_frequency_word_ff[7:0];
         ADDR_PLL:    rd_mux = {5'h00, ln_req_ff, bw_ff};
         ADDR_OSC:    rd_mux = {6'h00, rc_done_ff, 1'b0};
         ADDR_MAP2:   rd_mux = {5'h00, clksel_ff};
         ADDR_FRAC:   rd_mux = {4'h0, frac_ff};
         ADDR_REFSRC: rd_mux = {7'h00, external_reference_select_ff};
         ADDR_STATUS: rd_mux = {5'h00, rc_done_ff, pll_start_ff,
                                xo_s};
         default:     rd_mux = 8'h00;
      endcase
   endfunction

   assign wdata = {sh_ff[6:0], mosi_s};

   // Mode 0 serial slave: address byte with write bit, then data.
   always_comb begin
      nxt_bcnt_ff = bcnt_ff;
      nxt_sh_ff   = sh_ff;
      nxt_osh_ff  = osh_ff;
      nxt_addr_ff = addr_ff;
      nxt_wr_ff   = wr_ff;
      nxt_ph_ff   = ph_ff;
      nxt_miso_ff = spi_miso_ff;
      wr_stb      = 1'b0;
      if (nss_s) begin
         nxt_bcnt_ff = 4'h0;
         nxt_ph_ff   = 1'b0;
         nxt_miso_ff = 1'b0;
      end else begin
         if (sck_rise) begin
            nxt_sh_ff   = wdata;
            nxt_bcnt_ff = bcnt_ff + 4'h1;
            if (bcnt_ff == 4'h7) begin
               nxt_bcnt_ff = 4'h0;
               if (!ph_ff) begin
                  nxt_ph_ff   = 1'b1;
                  nxt_wr_ff   = sh_ff[SPI_WR_BIT - 1];
                  nxt_addr_ff = wdata[6:0];
                  nxt_osh_ff  = rd_mux(wdata[6:0]);
               end else begin
                  wr_stb = wr_ff;
               end
            end
         end
         if (sck_fall && ph_ff) begin
            nxt_miso_ff = osh_ff[7];
            nxt_osh_ff  = {osh_ff[6:0], 1'b0};
         end
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         bcnt_ff        <= 4'h0;
         sh_ff          <= 8'h00;
         osh_ff         <= 8'h00;
         addr_ff        <= 7'h00;
         wr_ff          <= 1'b0;
         ph_ff          <= 1'b0;
         spi_miso_ff    <= 1'b0;
         spi_miso_oe_ff <= 1'b0;
      end else begin
         bcnt_ff        <= nxt_bcnt_ff;
         sh_ff          <= nxt_sh_ff;
         osh_ff         <= nxt_osh_ff;
         addr_ff        <= nxt_addr_ff;
         wr_ff          <= nxt_wr_ff;
         ph_ff          <= nxt_ph_ff;
         spi_miso_ff    <= nxt_miso_ff;
         spi_miso_oe_ff <= !nss_s;
      end
   end

   // Register writes.
   always_comb begin
      nxt_mode_ff    = mode_ff;
      nxt_ook_ff     = ook_ff;
      nxt_gauss_ff   = gauss_ff;
      nxt_cont_ff    = cont_ff;
      nxt_br_hi_ff   = br_hi_ff;
      nxt_br_lo_ff   = br_lo_ff;
      nxt_frac_ff    = frac_ff;
      nxt_frf_hi_ff  = frf_hi_ff;
      nxt_frf_md_ff  = frf_md_ff;
      nxt_frf_ff     = carrier_frequency_word_ff;
      nxt_bw_ff      = bw_ff;
      nxt_ln_req_ff  = ln_req_ff;
      nxt_clksel_ff  = clksel_ff;
      nxt_ext_ref_ff = external_reference_select_ff;
      if (wr_stb) begin
         unique case (addr_ff)
            ADDR_OPMODE: begin
               nxt_mode_ff  = wdata[2:0];
               nxt_ook_ff   = wdata[OPM_OOK_BIT];
               nxt_gauss_ff = wdata[OPM_GAUSS_BIT];
               nxt_cont_ff  = wdata[OPM_CONT_BIT];
            end
            ADDR_BR_HI:  nxt_br_hi_ff = wdata;
            ADDR_BR_LO:  nxt_br_lo_ff = wdata;
            ADDR_FRAC:   nxt_frac_ff = wdata[3:0];
            // Upper bytes only wait; the low byte commits all three,
            // which lets software hop without passing odd frequencies.
            ADDR_FRF_HI: nxt_frf_hi_ff = wdata;
            ADDR_FRF_MD: nxt_frf_md_ff = wdata;
            ADDR_FRF_LO: nxt_frf_ff = {frf_hi_ff, frf_md_ff,
                                       wdata};
            ADDR_PLL: begin
               nxt_bw_ff     = wdata[1:0];
               nxt_ln_req_ff = wdata[PLL_LN_BIT];
            end
            ADDR_MAP2:   nxt_clksel_ff = wdata[2:0];
            ADDR_REFSRC: nxt_ext_ref_ff = wdata[0];
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         mode_ff   <= RST_OPMODE[2:0];
         ook_ff    <= RST_OPMODE[OPM_OOK_BIT];
         gauss_ff  <= RST_OPMODE[OPM_GAUSS_BIT];
         cont_ff   <= RST_OPMODE[OPM_CONT_BIT];
         br_hi_ff  <= RST_BR_HI;
         br_lo_ff  <= RST_BR_LO;
         frac_ff   <= RST_FRAC;
         frf_hi_ff <= RST_FRF;
         frf_md_ff <= RST_FRF;
         // The word drives steps of crystal over two to the 19th.
         carrier_frequency_word_ff <= {3{RST_FRF}};
         bw_ff     <= RST_PLL[1:0];
         ln_req_ff <= RST_PLL[PLL_LN_BIT];
         clksel_ff <= RST_CLKSEL;
         external_reference_select_ff <= 1'b0;
      end else begin
         mode_ff   <= nxt_mode_ff;
         ook_ff    <= nxt_ook_ff;
         gauss_ff  <= nxt_gauss_ff;
         cont_ff   <= nxt_cont_ff;
         br_hi_ff  <= nxt_br_hi_ff;
         br_lo_ff  <= nxt_br_lo_ff;
         frac_ff   <= nxt_frac_ff;
         frf_hi_ff <= nxt_frf_hi_ff;
         frf_md_ff <= nxt_frf_md_ff;
         carrier_frequency_word_ff <= nxt_frf_ff;
         bw_ff     <= nxt_bw_ff;
         ln_req_ff <= nxt_ln_req_ff;
         clksel_ff <= nxt_clksel_ff;
         external_reference_select_ff <= nxt_ext_ref_ff;
      end
   end

   // RC calibration, PLL start, reference output and bit timing.
   sfbc_rc_e    rc_st_ff, nxt_rc_st_ff;
   logic [7:0]  rc_cnt_ff, nxt_rc_cnt_ff;
   logic        nxt_rc_done_ff;
   logic        rc_trig;
   logic [6:0]  div_cnt_ff;
   logic        nxt_clk_out;
   logic        nxt_transmit_bit_clock;
   logic        nxt_txd;
   logic        tx_mode;
   logic        sync_mode;
   sfbc_bit_if  bi ();

   assign rc_trig = wr_stb && (addr_ff == ADDR_OSC) &&
                    wdata[OSC_TRIG_BIT];
   assign tx_mode   = (mode_ff == MODE_TX);
   assign sync_mode = cont_ff && gauss_ff;
   assign bi.div_int  = {br_hi_ff, br_lo_ff};
   assign bi.div_frac = ook_ff ? 4'h0 : frac_ff;
   assign bi.run      = tx_mode && (!cont_ff || gauss_ff);

   sfbc_bit_gen u_bit_gen (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .b        (bi)
   );

   always_comb begin
      nxt_rc_st_ff   = rc_st_ff;
      nxt_rc_cnt_ff  = rc_cnt_ff + 8'h01;
      nxt_rc_done_ff = rc_done_ff;
      if (rc_trig) begin
         nxt_rc_st_ff   = RC_RUN;
         nxt_rc_cnt_ff  = 8'h00;
         nxt_rc_done_ff = 1'b0;
      end else if (rc_st_ff == RC_RUN) begin
         if (rc_cnt_ff == 8'(RC_CAL_CYCLES - 1)) begin
            nxt_rc_st_ff   = RC_IDLE;
            nxt_rc_done_ff = 1'b1;
         end
      end else begin
         nxt_rc_cnt_ff = 8'h00;
      end
      nxt_clk_out = 1'b0;
      // Sleep stops the divided reference; unused, it only costs power.
      if (clksel_ff != REFERENCE_CLOCK_OUTPUT_OFF && mode_ff != MODE_SLEEP) begin
         nxt_clk_out = div_cnt_ff[clksel_ff];
      end
      nxt_transmit_bit_clock = 1'b0;
      if (bi.run && sync_mode) begin
         nxt_transmit_bit_clock = bi.tick ? 1'b1 :
                    (bi.half ? 1'b0 : serial_bit_clock_pin_ff);
      end
      nxt_txd = tx_mod_data_ff;
      if (cont_ff && !gauss_ff) begin
         nxt_txd = data_s;
      end else if (bi.half) begin
         // Sampled mid bit, well after the host reacts to the rise.
         nxt_txd = data_s;
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rc_st_ff   <= RC_RUN;
         rc_cnt_ff  <= 8'h00;
         rc_done_ff <= 1'b0;
         rc_cal_active_ff        <= 1'b1;
         div_cnt_ff              <= 7'h00;
         clock_output_pin_ff     <= 1'b0;
         serial_bit_clock_pin_ff <= 1'b0;
         tx_mod_data_ff          <= 1'b0;
         pll_start_ff            <= 1'b0;
         pll_low_noise_ff        <= 1'b0;
         pll_bandwidth_ff        <= RST_PLL[1:0];
      end else begin
         rc_st_ff   <= nxt_rc_st_ff;
         rc_cnt_ff  <= nxt_rc_cnt_ff;
         rc_done_ff <= nxt_rc_done_ff;
         rc_cal_active_ff        <= (nxt_rc_st_ff == RC_RUN);
         div_cnt_ff              <= div_cnt_ff + 7'h01;
         clock_output_pin_ff     <= nxt_clk_out;
         serial_bit_clock_pin_ff <= nxt_transmit_bit_clock;
         tx_mod_data_ff          <= nxt_txd;
         pll_start_ff            <= pll_start_ff || xo_s;
         pll_low_noise_ff        <= ln_req_ff && tx_mode;
         pll_bandwidth_ff        <= bw_ff;
      end
   end

   // Checks.
   sequence s_lo_write;
      wr_stb && addr_ff == ADDR_FRF_LO;
   endsequence
   sequence s_cal_trig;
      rc_trig;
   endsequence

   a_frf_commit: assert property (@(posedge core_clk)
      disable iff (!reset_n) s_lo_write |=>
      carrier_frequency_word_ff == {$past(frf_hi_ff),
                                    $past(frf_md_ff), $past(wdata)})
      else $error("frequency word not committed on low byte");
   a_frf_hold: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      (wr_stb && addr_ff != ADDR_FRF_LO) |=>
      $stable(carrier_frequency_word_ff))
      else $error("frequency word changed without low byte");
   a_pll_auto: assert property (@(posedge core_clk)
      disable iff (!reset_n) xo_stable [*3] |=> pll_start_ff)
      else $error("PLL did not start after crystal stable");
   a_rc_clear: assert property (@(posedge core_clk)
      disable iff (!reset_n) s_cal_trig |=> (!rc_done_ff) [*8])
      else $error("calibration done not held clear");
   a_rc_done: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      s_cal_trig |-> ##[1:RC_BOUND] (rc_done_ff || rc_trig))
      else $error("calibration done not set in time");
   a_clk_sleep: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      mode_ff == MODE_SLEEP |=> !clock_output_pin_ff)
      else $error("clock output active in sleep");
   a_pll_rx_low: assert property (@(posedge core_clk)
      disable iff (!reset_n) !tx_mode |=> !pll_low_noise_ff)
      else $error("low noise PLL outside transmit");
   a_ook_frac: assert property (@(posedge core_clk)
      disable iff (!reset_n) ook_ff |-> bi.div_frac == 4'h0)
      else $error("fraction used in on-off keying");
   a_transmit_bit_clock_pulse: assert property (@(posedge core_clk)
      disable iff (!reset_n)
      (bi.tick && bi.run && sync_mode) |=> serial_bit_clock_pin_ff)
      else $error("bit clock did not rise on new bit");
endmodule

// File: testbench/sfbc_host_model.sv
// Host side of the serial register port: mode 0 frames of two bytes.
`timescale 1ns/1ns
module sfbc_host_model (
   input  wire logic core_clk,
   output logic      spi_sck,
   output logic      spi_nss_n,
   output logic      spi_mosi,
   input  wire logic spi_miso
);
   localparam int HALF = 5;

   initial begin
      spi_sck = 1'b0;
      spi_nss_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // High halves of 50 ns and low halves of 60 ns leave the three-cycle output lag well settled.
   task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd,
                       output logic [7:0] rd);
      logic [15:0] sh;
      sh = {cmd, wd};
      rd = 8'h00;
      @(posedge core_clk);
      spi_nss_n <= 1'b0;
      for (int i = 15; i >= 0; i--) begin
         @(posedge core_clk);
         spi_mosi <= sh[i];
         repeat (HALF) @(posedge core_clk);
         spi_sck <= 1'b1;
         if (i < 8) begin
            rd[i] = spi_miso;
         end
         repeat (HALF) @(posedge core_clk);
         spi_sck <= 1'b0;
      end
      repeat (HALF) @(posedge core_clk);
      spi_nss_n <= 1'b1;
      spi_mosi <= ~sh[0];
      repeat (4) @(posedge core_clk);
   endtask
endmodule

// File: testbench/synth_freq_bitrate_control_tb.sv
// Self-checking bench for the synthesizer and bit rate control block.
`timescale 1ns/1ns
module synth_freq_bitrate_control_tb;
   import sfbc_pkg::*;
   logic        core_clk, reset_n, spi_sck, spi_nss_n, spi_mosi;
   logic        spi_miso_ff, spi_miso_oe_ff, miso_w;
   logic        miso_last = 1'b0;
   logic        serial_tx_data_pin, xo_stable, clock_output_pin_ff;
   logic        serial_bit_clock_pin_ff, tx_mod_data_ff, pll_low_noise_ff;
   logic        pll_start_ff, external_reference_select_ff;
   logic        rc_cal_active_ff, bit_q;
   logic [23:0] carrier_frequency_word_ff, frf;
   logic [1:0]  pll_bandwidth_ff;
   logic [7:0]  a, b, c;
   int          n_errors, compares, cyc, tot, dv, fr;

   sfbc_top u_dut (.core_clk, .reset_n, .spi_sck, .spi_nss_n, .spi_mosi,
      .spi_miso_ff, .spi_miso_oe_ff, .serial_tx_data_pin, .xo_stable,
      .clock_output_pin_ff, .serial_bit_clock_pin_ff, .tx_mod_data_ff,
      .carrier_frequency_word_ff, .pll_bandwidth_ff, .pll_low_noise_ff,
      .pll_start_ff, .external_reference_select_ff, .rc_cal_active_ff);

   sfbc_host_model u_host (.core_clk, .spi_sck, .spi_nss_n, .spi_mosi,
      .spi_miso(miso_w));

   // A released data line shows the inverse of its last value.
   always_ff @(posedge core_clk) begin
      if (spi_miso_oe_ff) begin
         miso_last <= spi_miso_ff;
      end
   end
   assign miso_w = spi_miso_oe_ff ? spi_miso_ff : ~miso_last;

   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end

   task automatic report_and_stop;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic cmp_val(input logic [23:0] got, input logic [23:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected value at %0t: %h vs %h", $time, got, exp);
      end
   endtask

   task automatic cmp_cnt(input int got, input int exp);
      compares++;
      if (got != exp) begin
         n_errors++;
         $display("unexpected count at %0t: %h vs %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [6:0] ad, input logic [7:0] d);
      logic [7:0] x;
      u_host.xfer({1'b1, ad}, d, x);
   endtask

   task automatic cmp_reg(input logic [6:0] ad, input logic [7:0] exp);
      logic [7:0] d;
      u_host.xfer({1'b0, ad}, 8'h00, d);
      cmp_val({16'h0000, d}, {16'h0000, exp});
   endtask

   function automatic logic pick(input bit w);
      return w ? serial_bit_clock_pin_ff : clock_output_pin_ff;
   endfunction

   // Counts edges up to the next rise; without one it stops at lim.
   task automatic next_rise(input bit w, input int lim, input bit quiet,
                            output int n);
      logic p;
      p = pick(w);
      n = 0;
      do begin
         @(posedge core_clk);
         n++;
         if (pick(w) && !p) break;
         p = pick(w);
      end while (n < lim);
      if (!quiet && n >= lim) begin
         n_errors++;
         report_and_stop();
      end
   endtask

   task automatic wait_cal(output int n);
      n = 0;
      while (rc_cal_active_ff !== 1'b0) begin
         @(posedge core_clk);
         n++;
         if (n > 400) begin
            n_errors++;
            report_and_stop();
         end
      end
   endtask

   initial begin
      reset_n = 1'b0;
      serial_tx_data_pin = 1'b0;
      xo_stable = 1'b0;
      n_errors = 0;
      compares = 0;
      frf = RST_FRF;
      void'($urandom(32'h1FFC));
      repeat (4) @(posedge core_clk);
      cmp_val(24'(rc_cal_active_ff), 24'h1);
      reset_n <= 1'b1;
      wait_cal(cyc);
      cmp_val(24'(cyc <= RC_CAL_CYCLES + 4), 24'h1);
      next_rise(0, 300, 0, cyc);
      next_rise(0, 300, 0, cyc);
      cmp_cnt(cyc, 2);
      cmp_val(24'(pll_start_ff), 24'h0);
      xo_stable <= 1'b1;
      repeat (6) @(posedge core_clk);
      cmp_val(24'(pll_start_ff), 24'h1);
      cmp_reg(ADDR_BR_HI, RST_BR_HI);
      cmp_reg(ADDR_BR_LO, RST_BR_LO);
      wr(7'h7F, 8'($urandom));
      cmp_reg(7'h7F, 8'h00);
      for (int k = 0; k < 2; k++) begin
         a = 8'($urandom);
         b = 8'($urandom);
         c = 8'($urandom);
         wr(ADDR_FRF_HI, a);
         wr(ADDR_FRF_MD, b);
         cmp_val(carrier_frequency_word_ff, frf);
         cmp_reg(ADDR_FRF_HI, frf[23:16]);
         wr(ADDR_FRF_LO, c);
         frf = {a, b, c};
         cmp_val(carrier_frequency_word_ff, frf);
      end
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_PLL, {5'h00, 1'b1, k[1:0]});
         wr(ADDR_OPMODE, {5'h00, MODE_TX});
         cmp_val(24'(pll_bandwidth_ff), 24'(k));
         cmp_val(24'(pll_low_noise_ff), 24'h1);
         wr(ADDR_OPMODE, RST_OPMODE);
         cmp_val(24'(pll_low_noise_ff), 24'h0);
      end
      wr(ADDR_OPMODE, {5'h00, MODE_SLEEP});
      next_rise(0, 300, 1, cyc);
      cmp_cnt(cyc, 300);
      wr(ADDR_OPMODE, RST_OPMODE);
      for (int s = 0; s < 8; s++) begin
         wr(ADDR_MAP2, 8'(s));
         next_rise(0, 300, s == 7, cyc);
         next_rise(0, 300, s == 7, cyc);
         cmp_cnt(cyc, s == 7 ? 300 : 2 << s);
      end
      wr(ADDR_REFSRC, 8'h01);
      cmp_val(24'(external_reference_select_ff), 24'h1);
      wr(ADDR_OSC, 8'h01);
      cmp_val(24'(rc_cal_active_ff), 24'h1);
      wait_cal(cyc);
      cmp_val(24'(cyc < RC_CAL_CYCLES), 24'h1);
      cmp_reg(ADDR_STATUS, 8'h07);
      wr(ADDR_OPMODE, 8'h23);
      repeat (8) begin
         bit_q = 1'($urandom);
         serial_tx_data_pin <= bit_q;
         repeat (4) @(posedge core_clk);
         cmp_val(24'(tx_mod_data_ff), 24'(bit_q));
      end
      // Sixteen bits carry the fraction exactly once in total, except under on-off keying (none).
      for (int k = 0; k < 3; k++) begin
         dv = k == 0 ? 1 : 8 + $urandom % 24;
         fr = k == 0 ? 0 : 1 + $urandom % 15;
         wr(ADDR_BR_HI, 8'h00);
         wr(ADDR_BR_LO, 8'(dv));
         wr(ADDR_FRAC, 8'(fr));
         wr(ADDR_OPMODE, k == 2 ? 8'h3B : 8'h33);
         next_rise(1, 2000, 0, cyc);
         tot = 0;
         for (int i = 0; i < 16; i++) begin
            bit_q = 1'($urandom);
            serial_tx_data_pin <= bit_q;
            next_rise(1, 2000, 0, cyc);
            tot += cyc;
            if (dv > 4) begin
               cmp_val(24'(tx_mod_data_ff), 24'(bit_q));
            end
         end
         cmp_cnt(tot, 16 * (dv < 2 ? 2 : dv) + (k == 2 ? 0 : fr));
      end
      report_and_stop();
   end
endmodule
